// ===== hw/rbc_top.sv
// RGB output blanking, cathode calibration start-up and status control with an APB register slave.
`timescale 1ns/10ps
`include "rbc_cfg.svh"
module rbc_top
    import rbc_pkg::*;
#(
    parameter int unsigned INHIBIT_CYCLES = `RBC_INHIBIT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        flyback_pin_i,
    input  wire logic        hsync_pin_i,
    input  wire logic        meas_valid_i,
    input  wire logic [9:0]  cutoff_red_i,
    input  wire logic [9:0]  cutoff_green_i,
    input  wire logic [9:0]  cutoff_blue_i,
    output logic             rgb_blank_o,
    output logic             cal_loop_active_o,
    output logic             osd_blend_mode_o,
    output logic             black_stretch_enable_o,
    output logic      [5:0]  contrast_o,
    output logic      [5:0]  saturation_o,
    output logic      [3:0]  drive_level_code_o
);
    // ****************************************
    // Register state
    // ****************************************
    logic [6:0]       ctrl;
    logic [7:0]       timing;
    logic [5:0]       contrast;
    logic [5:0]       saturation;
    logic [3:0]       drive_level_code;
    logic             loop_out_of_range_flag;
    logic             g2_window_flag;
    logic             cutoff_high_flag;
    logic             inhibit_busy;
    rbc_start_state_t start_state;
    rbc_start_state_t next_start_state;

    wire [1:0] horiz_output_release    = ctrl[`RBC_CTRL_RELEASE_MSB:`RBC_CTRL_RELEASE_LSB];
    wire       force_rgb_blank         = ctrl[`RBC_CTRL_FORCE_BLANK];
    wire       wide_blank_enable       = ctrl[`RBC_CTRL_WIDE_EN];
    wire       osd_blend_select        = ctrl[`RBC_CTRL_OSD_BLEND];
    wire       black_stretch_enable    = ctrl[`RBC_CTRL_BLACK_STR];
    wire       double_rate             = ctrl[`RBC_CTRL_DOUBLE_RATE];
    wire [3:0] counter_blank_start_adj = timing[`RBC_TIM_ADJ_LSB +: 4];
    wire [3:0] wide_blank_phase        = timing[`RBC_TIM_PHASE_LSB +: 4];

    // ****************************************
    // APB slave
    // ****************************************
    wire apb_setup = psel_i & ~penable_i;
    wire apb_done  = psel_i & penable_i & pready_o;
    wire hit_ctrl  = (paddr_i == `RBC_OFS_CTRL);
    wire hit_tim   = (paddr_i == `RBC_OFS_TIMING);
    wire hit_pic   = (paddr_i == `RBC_OFS_PICTURE);
    wire hit_stat  = (paddr_i == `RBC_OFS_STATUS);
    wire hit_any   = hit_ctrl | hit_tim | hit_pic | hit_stat;
    // Status is read-only, so a write to it is refused like an unmapped address.
    wire bad_acc   = ~hit_any | (hit_stat & pwrite_i);
    wire wr_ctrl   = apb_done & pwrite_i & hit_ctrl;
    wire wr_tim    = apb_done & pwrite_i & hit_tim;
    wire wr_pic    = apb_done & pwrite_i & hit_pic;

    wire [31:0] pic_word  = {12'h000, drive_level_code, 2'b00, saturation, 2'b00, contrast};
    wire [31:0] stat_word = {26'h000_0000, (start_state == RBC_ST_WARMUP), inhibit_busy, rgb_blank_o,
                             cutoff_high_flag, g2_window_flag, loop_out_of_range_flag};
    wire [31:0] read_word = hit_ctrl ? {25'h000_0000, ctrl} :
                            hit_tim  ? {24'h00_0000, timing} :
                            hit_pic  ? pic_word :
                            hit_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup & bad_acc;
            prdata_o  <= (apb_setup & ~pwrite_i) ? read_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl             <= `RBC_CTRL_RESET;
            timing           <= `RBC_TIM_RESET;
            contrast         <= `RBC_CONTRAST_RESET;
            saturation       <= `RBC_SAT_RESET;
            drive_level_code <= `RBC_DRIVE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata_i[6:0];
            end
            if (wr_tim) begin
                timing <= pwdata_i[7:0];
            end
            if (wr_pic) begin
                contrast         <= pwdata_i[`RBC_PIC_CONTRAST_LSB +: 6];
                saturation       <= pwdata_i[`RBC_PIC_SAT_LSB +: 6];
                drive_level_code <= pwdata_i[`RBC_PIC_DRIVE_LSB +: 4];
            end
        end
    end

    // ****************************************
    // Timing pins
    // ****************************************
    rbc_edge_if edges ();

    rbc_pin_sync u_pin_sync (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .flyback_pin_i (flyback_pin_i),
        .hsync_pin_i   (hsync_pin_i),
        .edges         (edges.sync_side)
    );

    // ****************************************
    // Counter blanking around the flyback pulse
    // ****************************************
    // The flyback centre is only known after the fact, so the start is predicted from the
    // previous line period and flyback width, counted from the previous leading edge.
    rbc_count_t fb_cnt;
    rbc_count_t line_period;
    rbc_count_t fb_width;
    logic       period_valid;
    logic       counter_blank;

    wire rbc_count_t blank_target = line_period + {1'b0, fb_width[11:1]}
                                    - 12'(`RBC_BLANK_LEAD_PULSES)
                                    - {8'h00, counter_blank_start_adj};
    wire rbc_count_t next_fb_cnt  = edges.flyback_rise ? 12'h000 :
                                    (fb_cnt == 12'hFFF) ? fb_cnt : fb_cnt + 12'h001;
    wire             blank_begin  = period_valid & ~edges.flyback_rise & (fb_cnt == blank_target);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Starting saturated keeps the partial line after reset from posing as a period.
            fb_cnt        <= 12'hFFF;
            line_period   <= 12'h000;
            fb_width      <= 12'h000;
            period_valid  <= 1'b0;
            counter_blank <= 1'b0;
        end else begin
            fb_cnt <= next_fb_cnt;
            if (edges.flyback_rise) begin
                line_period  <= fb_cnt;
                period_valid <= (fb_cnt != 12'hFFF);
            end
            if (edges.flyback_fall) begin
                fb_width <= fb_cnt;
            end
            if (edges.flyback_fall) begin
                counter_blank <= 1'b0;
            end else if (blank_begin) begin
                counter_blank <= 1'b1;
            end
        end
    end

    // ****************************************
    // Wide blanking tied to horizontal sync
    // ****************************************
    rbc_count_t h_cnt;
    rbc_count_t blank_start_h;
    rbc_count_t blank_len;
    logic       wide_blank;

    wire rbc_count_t wb_ext     = double_rate ? 12'(`RBC_WB_EXT_CYC_2FH) : 12'(`RBC_WB_EXT_CYC_1FH);
    wire rbc_count_t wb_phase   = 12'({8'h00, wide_blank_phase} * `RBC_WB_PHASE_STEP);
    wire rbc_count_t wb_centre  = 12'(`RBC_WB_PHASE_CENTRE * `RBC_WB_PHASE_STEP);
    wire rbc_count_t wide_start = blank_start_h - wb_ext + wb_phase - wb_centre;
    wire rbc_count_t wide_end   = wide_start + blank_len + {wb_ext[10:0], 1'b0};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_cnt         <= 12'h000;
            blank_start_h <= 12'h000;
            blank_len     <= 12'h000;
            wide_blank    <= 1'b0;
        end else begin
            h_cnt <= edges.hsync_rise ? 12'h000 : h_cnt + 12'h001;
            if (blank_begin) begin
                blank_start_h <= h_cnt;
            end
            if (edges.flyback_fall) begin
                blank_len <= h_cnt - blank_start_h;
            end
            if (h_cnt == wide_start) begin
                wide_blank <= 1'b1;
            end else if (h_cnt == wide_end) begin
                wide_blank <= 1'b0;
            end
        end
    end

    // ****************************************
    // Start-up blanking and calibration loop
    // ****************************************
    logic released_q;

    wire released      = &horiz_output_release;
    wire release_rise  = released & ~released_q;

    rbc_hold_timer #(
        .HOLD_CYCLES (INHIBIT_CYCLES)
    ) u_inhibit (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (release_rise),
        .cancel_i (~released),
        .busy_o   (inhibit_busy)
    );

    wire red_bad   = (cutoff_red_i < `RBC_LVL_LOW) | (cutoff_red_i > `RBC_LVL_HIGH);
    wire green_bad = (cutoff_green_i < `RBC_LVL_LOW) | (cutoff_green_i > `RBC_LVL_HIGH);
    wire blue_bad  = (cutoff_blue_i < `RBC_LVL_LOW) | (cutoff_blue_i > `RBC_LVL_HIGH);
    wire any_bad   = red_bad | green_bad | blue_bad;
    wire rbc_level_t low_rg = (cutoff_red_i < cutoff_green_i) ? cutoff_red_i : cutoff_green_i;
    wire rbc_level_t lowest = (low_rg < cutoff_blue_i) ? low_rg : cutoff_blue_i;
    wire g2_in_window = (lowest >= `RBC_G2_WIN_LO) & (lowest <= `RBC_G2_WIN_HI);
    wire lowest_high  = (lowest > `RBC_CUTOFF_HIGH);

    // A release always marks the loop out of range, so a warm tube still waits out the inhibit.
    wire oor_set    = release_rise | (meas_valid_i & any_bad);
    wire oor_clear  = meas_valid_i & ~any_bad & ~inhibit_busy;
    wire next_oor   = oor_set ? 1'b1 : (oor_clear ? 1'b0 : loop_out_of_range_flag);
    wire oor_fall   = loop_out_of_range_flag & ~next_oor;

    always_comb begin
        next_start_state = start_state;
        case (start_state)
            RBC_ST_OFF: begin
                if (release_rise) begin
                    next_start_state = RBC_ST_WARMUP;
                end
            end
            RBC_ST_WARMUP: begin
                if (!released) begin
                    next_start_state = RBC_ST_OFF;
                end else if (oor_fall) begin
                    next_start_state = RBC_ST_RUN;
                end
            end
            RBC_ST_RUN: begin
                if (!released) begin
                    next_start_state = RBC_ST_OFF;
                end
            end
            default: begin
                next_start_state = RBC_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            released_q             <= 1'b0;
            start_state            <= RBC_ST_OFF;
            loop_out_of_range_flag <= 1'b0;
            g2_window_flag         <= 1'b0;
            cutoff_high_flag       <= 1'b0;
        end else begin
            released_q             <= released;
            start_state            <= next_start_state;
            loop_out_of_range_flag <= next_oor;
            if (meas_valid_i) begin
                g2_window_flag   <= g2_in_window;
                cutoff_high_flag <= lowest_high;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Force blank overrides everything; the host decides when it is safe to drop it.
    wire next_blank = force_rgb_blank | (next_start_state == RBC_ST_WARMUP) | counter_blank
                      | (wide_blank_enable & wide_blank);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rgb_blank_o            <= 1'b1;
            cal_loop_active_o      <= 1'b0;
            osd_blend_mode_o       <= 1'b0;
            black_stretch_enable_o <= 1'b0;
            contrast_o             <= `RBC_CONTRAST_RESET;
            saturation_o           <= `RBC_SAT_RESET;
            drive_level_code_o     <= `RBC_DRIVE_RESET;
        end else begin
            rgb_blank_o            <= next_blank;
            cal_loop_active_o      <= (next_start_state != RBC_ST_OFF);
            osd_blend_mode_o       <= osd_blend_select;
            black_stretch_enable_o <= black_stretch_enable;
            contrast_o             <= contrast;
            saturation_o           <= saturation;
            drive_level_code_o     <= drive_level_code;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_force_blanks: assert property (@(posedge clk_i) disable iff (rst_i)
        force_rgb_blank |=> rgb_blank_o)
        else $error("force blank did not blank the outputs");

    a_blank_ends_trail: assert property (@(posedge clk_i) disable iff (rst_i)
        edges.flyback_fall |=> !counter_blank)
        else $error("counter blank outlived the flyback trailing edge");

    a_blank_start_pos: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(counter_blank) |-> $past(fb_cnt) == $past(blank_target))
        else $error("counter blank started at the wrong count");

    a_wide_start_pos: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wide_blank) |-> $past(h_cnt) == $past(wide_start))
        else $error("wide blank started at the wrong phase");

    a_oor_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        (meas_valid_i && any_bad) |=> loop_out_of_range_flag)
        else $error("out-of-range level did not set the flag");

    a_oor_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
        (inhibit_busy && loop_out_of_range_flag) |=> loop_out_of_range_flag)
        else $error("flag cleared during the inhibit time");

    a_release_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        release_rise |=> (start_state == RBC_ST_WARMUP) ##1 (rgb_blank_o && cal_loop_active_o))
        else $error("release did not blank and start the loop");

    a_unblank_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_state == RBC_ST_WARMUP && released && loop_out_of_range_flag) ##1 !loop_out_of_range_flag
        |-> start_state == RBC_ST_RUN)
        else $error("start-up blank not removed when flag fell");

    a_g2_window: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_valid_i |=> g2_window_flag == ($past(lowest) >= 10'd240 && $past(lowest) <= 10'd260))
        else $error("g2 window flag wrong");

    a_cutoff_high: assert property (@(posedge clk_i) disable iff (rst_i)
        meas_valid_i |=> cutoff_high_flag == ($past(lowest) > 10'd260))
        else $error("cut-off-high flag wrong");

    a_blend_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ##1 osd_blend_mode_o == $past(pwdata_i[4], 2))
        else $error("blend select not applied");
endmodule

// ===== hw/rbc_cfg.svh
// Offsets, field positions, reset values and timing counts of the RGB blanking control block.
`ifndef RBC_CFG_SVH
`define RBC_CFG_SVH

// ****************************************
// Clock
// ****************************************
`define RBC_CLK_KHZ           20000

// ****************************************
// Register offsets
// ****************************************
`define RBC_OFS_CTRL          8'h00
`define RBC_OFS_TIMING        8'h04
`define RBC_OFS_PICTURE       8'h08
`define RBC_OFS_STATUS        8'h0C

// ****************************************
// Control register fields
// ****************************************
`define RBC_CTRL_RELEASE_LSB  0
`define RBC_CTRL_RELEASE_MSB  1
`define RBC_CTRL_FORCE_BLANK  2
`define RBC_CTRL_WIDE_EN      3
`define RBC_CTRL_OSD_BLEND    4
`define RBC_CTRL_BLACK_STR    5
`define RBC_CTRL_DOUBLE_RATE  6
`define RBC_CTRL_RESET        7'h00

// ****************************************
// Timing and picture register fields
// ****************************************
`define RBC_TIM_ADJ_LSB       0
`define RBC_TIM_PHASE_LSB     4
`define RBC_TIM_RESET         8'h00
`define RBC_PIC_CONTRAST_LSB  0
`define RBC_PIC_SAT_LSB       8
`define RBC_PIC_DRIVE_LSB     16
`define RBC_CONTRAST_RESET    6'h20
`define RBC_SAT_RESET         6'h16
`define RBC_DRIVE_RESET       4'h8

// ****************************************
// Blanking timing
// ****************************************
`define RBC_BLANK_LEAD_PULSES 40
`define RBC_WB_EXT_NS_1FH     1000
`define RBC_WB_EXT_NS_2FH     500
`define RBC_WB_EXT_CYC_1FH    ((`RBC_WB_EXT_NS_1FH * `RBC_CLK_KHZ) / 1000000)
`define RBC_WB_EXT_CYC_2FH    ((`RBC_WB_EXT_NS_2FH * `RBC_CLK_KHZ) / 1000000)
`define RBC_WB_PHASE_STEP     4
`define RBC_WB_PHASE_CENTRE   8
`define RBC_INHIBIT_MS        500
`define RBC_INHIBIT_CYCLES    (`RBC_INHIBIT_MS * `RBC_CLK_KHZ)

// ****************************************
// Cut-off levels, in units of 10 mV
// ****************************************
`define RBC_LVL_LOW           10'd150
`define RBC_LVL_HIGH          10'd350
`define RBC_G2_WIN_LO         10'd240
`define RBC_G2_WIN_HI         10'd260
`define RBC_CUTOFF_HIGH       10'd260

`endif

// ===== hw/rbc_pkg.sv
// Types shared by the RGB blanking control modules.
package rbc_pkg;

    typedef logic [9:0]  rbc_level_t;
    typedef logic [11:0] rbc_count_t;

    typedef enum logic [1:0] {
        RBC_ST_OFF    = 2'b00,
        RBC_ST_WARMUP = 2'b01,
        RBC_ST_RUN    = 2'b10
    } rbc_start_state_t;

endpackage

// ===== hw/rbc_edge_if.sv
// Synchronised timing pins and their edge pulses, from the pin synchroniser to the core.
`timescale 1ns/10ps
interface rbc_edge_if;
    logic flyback;
    logic flyback_rise;
    logic flyback_fall;
    logic hsync_rise;

    modport sync_side (output flyback, output flyback_rise, output flyback_fall, output hsync_rise);
    modport core_side (input flyback, input flyback_rise, input flyback_fall, input hsync_rise);
endinterface

// ===== hw/rbc_pin_sync.sv
// Two-stage synchroniser and edge detector for the flyback and horizontal sync pins.
`timescale 1ns/10ps
module rbc_pin_sync
    import rbc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       flyback_pin_i,
    input  wire logic       hsync_pin_i,
    rbc_edge_if.sync_side   edges
);
    logic [1:0] pin_raw;
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;

    assign pin_raw = {hsync_pin_i, flyback_pin_i};

    // The edge detector looks only at the second and third stages.
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                stage1[i] <= 1'b0;
                stage2[i] <= 1'b0;
                stage3[i] <= 1'b0;
            end else begin
                stage1[i] <= pin_raw[i];
                stage2[i] <= stage1[i];
                stage3[i] <= stage2[i];
            end
        end
    end

    assign edges.flyback      = stage2[0];
    assign edges.flyback_rise = stage2[0] & ~stage3[0];
    assign edges.flyback_fall = ~stage2[0] & stage3[0];
    assign edges.hsync_rise   = stage2[1] & ~stage3[1];
endmodule

// ===== hw/rbc_hold_timer.sv
// Retriggerable hold timer that stays busy for a set number of clock cycles after a start pulse.
`timescale 1ns/10ps
module rbc_hold_timer #(
    parameter int unsigned HOLD_CYCLES = 32'd1000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic cancel_i,
    output logic      busy_o
);
    logic [31:0] remain;
    logic [31:0] next_remain;

    assign next_remain = start_i            ? HOLD_CYCLES :
                         cancel_i           ? 32'h0000_0000 :
                         (remain != 32'h0000_0000) ? remain - 32'h0000_0001 :
                                              32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remain <= 32'h0000_0000;
            busy_o <= 1'b0;
        end else begin
            remain <= next_remain;
            busy_o <= (next_remain != 32'h0000_0000);
        end
    end
endmodule

// ===== test/rbc_line_model.sv
// Deflection side model: flyback and horizontal sync pulses once per line.
`timescale 1ns/10ps
module rbc_line_model #(
    parameter int PERIOD = 200,
    parameter int FLY_W  = 20
) (
    input  wire logic clk_i,
    output logic      flyback_o,
    output logic      hsync_o
);
    int cnt = 0;
    // The sync pulse leads; flyback sits late in the line, as on a real tube.
    always @(posedge clk_i) begin
        cnt <= (cnt + 1) % PERIOD;
    end
    assign hsync_o   = (cnt < 10);
    assign flyback_o = (cnt >= PERIOD - 40) && (cnt < PERIOD - 40 + FLY_W);
endmodule

// ===== test/rbc_top_tb_top.sv
// Self-checking bench for the RGB blanking control block.
`timescale 1ns/10ps
`include "rbc_cfg.svh"
module rbc_top_tb_top;
    logic        clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, mv = 0;
    logic [7:0]  pa = 0;
    logic [31:0] pwd = 0, seed = 32'h5876_0c92, ctl;
    logic [9:0]  r = 0, g = 0, b = 0, mn;
    logic [31:0] prd;
    logic        prdy, perr, fly, hs, blk, cal, bl, bs;
    logic [65:0] notes[$];
    logic [65:0] nt;
    int          n_errors = 0, checks_done = 0, w;
    // ****
    // Clock, design and line model
    // ****
    always #25 clk_i = ~clk_i;
    rbc_top #(.INHIBIT_CYCLES(50)) dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .flyback_pin_i(fly), .hsync_pin_i(hs), .meas_valid_i(mv), .cutoff_red_i(r), .cutoff_green_i(g),
        .cutoff_blue_i(b), .rgb_blank_o(blk), .cal_loop_active_o(cal), .osd_blend_mode_o(bl),
        .black_stretch_enable_o(bs), .contrast_o(), .saturation_o(), .drive_level_code_o());
    rbc_line_model lm (.clk_i(clk_i), .flyback_o(fly), .hsync_o(hs));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Bus answers are judged against the oldest note; unknown bits are masked out.
    always @(posedge clk_i) begin
        if (prdy === 1'b1) begin
            nt = notes.pop_front();
            check({perr, prd} & nt[65:33], nt[32:0]);
        end
    end
    task automatic apb(input logic w_i, input logic [7:0] a, input logic [31:0] d, input logic [65:0] n);
        notes.push_back(n);
        @(posedge clk_i);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w_i, a, d};
        @(posedge clk_i);
        pen <= 1;
        do @(posedge clk_i); while (prdy !== 1'b1);
        {psel, pen} <= 2'b00;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [32:0] st(input logic f, input logic busy, input logic warm);
        return {27'h0, warm, busy, 1'b0, mn > 10'd260, mn >= 10'd240 && mn <= 10'd260, f};
    endfunction
    task automatic meas(input logic bad);
        logic [9:0] rn, gn, bn;
        seed = lfsr(lfsr(seed));
        rn = bad ? 10'd100 : 10'd150 + 10'(seed[9:0] % 201);
        gn = 10'd150 + 10'(seed[19:10] % 201);
        bn = 10'd150 + 10'(seed[29:20] % 201);
        mn = (rn < gn) ? ((rn < bn) ? rn : bn) : ((gn < bn) ? gn : bn);
        @(posedge clk_i);
        {r, g, b, mv} <= {rn, gn, bn, 1'b1};
        @(posedge clk_i);
        mv <= 0;
    endtask
    task automatic blank_width;
        while (blk !== 1'b0) @(posedge clk_i);
        while (blk !== 1'b1) @(posedge clk_i);
        w = 0;
        while (blk === 1'b1) begin
            @(posedge clk_i);
            w++;
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        apb(0, `RBC_OFS_PICTURE, 0, {33'h1_ffff_ffff, 33'h0_0008_1620});
        apb(0, 8'h10, 0, {33'h1_ffff_ffff, 33'h1_0000_0000});
        apb(1, `RBC_OFS_STATUS, 1, {33'h1_ffff_ffff, 33'h1_0000_0000});
        for (int adj = 0; adj < 16; adj += 15) begin
            apb(1, `RBC_OFS_TIMING, 32'h80 + adj, {66'h0});
            apb(0, `RBC_OFS_TIMING, 0, {33'h1_ffff_ffff, 33'(32'h80 + adj)});
            blank_width();
            check(33'(w), 33'(10 + 40 + adj + 1));
        end
        seed = lfsr(seed);
        ctl = {26'h0, seed[1:0], 4'h0};
        for (int k = 0; k < 2; k++) begin
            apb(1, `RBC_OFS_CTRL, ctl, {66'h0});
            repeat (2) @(posedge clk_i);
            check({31'h0, bl, bs}, {31'h0, ctl[4], ctl[5]});
            ctl = ctl ^ 32'h30;
        end
        apb(1, `RBC_OFS_CTRL, ctl | 3, {66'h0});
        meas(0);
        apb(0, `RBC_OFS_STATUS, 0, {33'h1_0000_0037, st(1, 1, 1)});
        check({32'h0, cal}, 33'h1);
        repeat (60) @(posedge clk_i);
        meas(0);
        apb(0, `RBC_OFS_STATUS, 0, {33'h1_0000_0037, st(0, 0, 0)});
        meas(1);
        apb(0, `RBC_OFS_STATUS, 0, {33'h1_0000_0037, st(1, 0, 0)});
        apb(1, `RBC_OFS_CTRL, ctl | 7, {66'h0});
        meas(0);
        w = 0;
        repeat (400) @(posedge clk_i) w += (blk !== 1'b1);
        check(33'(w), 33'h0);
        apb(1, `RBC_OFS_CTRL, ctl | 3, {66'h0});
        blank_width();
        check(33'(w), 33'(10 + 40 + 15 + 1));
        apb(1, `RBC_OFS_CTRL, ctl | 32'h4B, {66'h0});
        blank_width();
        blank_width();
        check(33'(w), 33'(10 + 40 + 15 + 1 + 2 * 10));
        apb(1, `RBC_OFS_CTRL, ctl | 32'hB, {66'h0});
        apb(1, `RBC_OFS_TIMING, 32'h0F, {66'h0});
        blank_width();
        blank_width();
        check(33'(w), 33'(10 + 40 + 15 + 1 + 20 + 8 * 4));
        wrap_up();
    end
endmodule
